// ==== bcc_clock_calendar.v ====
/*
  BCD real-time clock and calendar with alarm, drift calibration and a
  selectable clock output pin, reached as an APB slave.
  Assumes the 32.768 kHz source levels are synchronous to pclk and that
  presetn is the power-on reset; other system resets do not reach here.
*/
// Decided for this implementation: the APB register port and the register offsets.
// What this block does
// - Calendar runs 2000-01-01 00:00:00 to 2099-12-31 23:59:59, 24-hour.
// - Leap years detected automatically; February gets its 29th day.
// - Time and date fields kept in BCD tens and ones digits; weekday is a single 3-bit digit 0 to 6.
// - Seconds come from 32.768 kHz source; half second is visible.
// - Module enable bit runs the clock when set, stops it when clear.
// - Value window writes are ignored unless value write enable is set.
// - Module enable bit is written only while value write enable is 1.
// - Sync status reads 1 while a rollover ripple may corrupt reads.
// - Writing the seconds field forces half-second status to 0.
// - Output enable gates the selected clock onto the output pin.
// - Value pointer selects minutes/weekday/month and seconds/hours/day/year.
// - Each high value window access decrements the pointer, stopping at 00.
// - Configuration reset only at power-on; clock runs through other resets.
// - Signed calibration removes four source pulses per positive step once a minute.
// - Select 10 routes raw source clock chosen by fuse; 11 reserved.
// - Select 01 routes the seconds clock, 00 the alarm pulse.
// - Alarm mask chooses interval from half second to yearly.
// - Repeat count decrements per alarm; wraps only with chime; enable clears.
// - High alarm window access decrements alarm pointer, stopping at 00.
`timescale 1ns/100ps
`include "bcc_defs.vh"

module bcc_clock_calendar
#(
  parameter ADDR_W = 8
)
(
  // APB slave
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Source oscillators and fuse
  input  wire              internal_oscillator,
  input  wire              secondary_oscillator,
  input  wire              source_osc_fuse,
  // Clock output pin
  output reg               clock_out_r
);

  // Two-digit BCD increment with wrap to lo at lim; bit 8 is the carry
  function [8:0] bcd_inc;
    input [7:0] v;
    input [7:0] lim;
    input [7:0] lo;
    begin
      if (v >= lim)
        bcd_inc = {1'b1, lo};
      else if (v[3:0] == 4'h9)
        bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last day of month in BCD; every year divisible by four is leap
  function [7:0] last_day;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      case (mon)
        8'h02:   last_day = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
        default: last_day = 8'h31;
      endcase
    end
  endfunction

  // Registers
  reg        en_r, wren_r, oe_r, half_r, cal_pend_r, src_d_r;
  reg  [1:0] ptr_r, aptr_r, sel_r;
  reg  [7:0] cal_r, rpt_r;
  reg        al_en_r, chime_r, chk_r, chk_sec_r, al_pulse_r;
  reg  [3:0] mask_r;
  reg  [15:0] presc_r;
  reg  [7:0] sec_r, min_r, hour_r, day_r, mon_r, year_r;
  reg  [2:0] wday_r;
  reg  [7:0] asec_r, amin_r, ahr_r, aday_r, amon_r;
  reg  [2:0] awd_r;
  reg  [7:0] sec_nxt, min_nxt, hour_nxt, day_nxt, mon_nxt, year_nxt;
  reg  [2:0] wday_nxt;
  reg        min_carry;
  reg  [8:0] t;
  reg  [7:0] rd_nxt;
  reg        mapped;

  // Bus decode
  wire [7:0] a8      = paddr[7:0];
  wire       wr_done = psel & penable & pready & pwrite;
  wire       acc_end = psel & penable & pready;
  wire       hit_valh = acc_end & (a8 == `BCC_OFF_VALH);
  wire       hit_alvh = acc_end & (a8 == `BCC_OFF_ALVALH);
  wire       wr_vall = wr_done & (a8 == `BCC_OFF_VALL) & wren_r;
  wire       wr_valh = wr_done & (a8 == `BCC_OFF_VALH) & wren_r;
  wire       wr_sec  = wr_vall & (ptr_r == 2'h0);

  // Source clock edge, chosen by the fuse
  wire src_lvl  = source_osc_fuse ? secondary_oscillator
                                  : internal_oscillator;
  wire src_tick = src_lvl & ~src_d_r & en_r;

  // Second length, trimmed once a minute by 4 x signed calibration
  wire [15:0] cal_x4 = {{6{cal_r[7]}}, cal_r, 2'b00};
  wire [15:0] term   = cal_pend_r ? `BCC_SEC_LAST - cal_x4
                                  : `BCC_SEC_LAST;
  wire        sec_tick  = src_tick & (presc_r >= term);
  wire        half_tick = src_tick & (presc_r == `BCC_HALF_POINT - 16'h1);
  wire [15:0] to_go     = term - presc_r;
  wire        sync_now  = en_r & (to_go <= `BCC_SYNC_TICKS);

  // Prescaler, half-second status and calibration pending
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_r    <= 16'h0000;
      half_r     <= 1'b0;
      cal_pend_r <= 1'b0;
      src_d_r    <= 1'b0;
    end
    else
    begin
      src_d_r <= src_lvl;
      if (wr_sec)
      begin
        presc_r <= 16'h0000;
        half_r  <= 1'b0;
      end
      else if (sec_tick)
      begin
        presc_r <= 16'h0000;
        half_r  <= 1'b0;
      end
      else if (src_tick)
      begin
        presc_r <= presc_r + 16'h1;
        if (half_tick)
          half_r <= 1'b1;
      end
      if (sec_tick)
        cal_pend_r <= min_carry;
    end
  end

  // Calendar roll-over, then software writes on top
  always @*
  begin
    sec_nxt = sec_r;
    min_nxt = min_r;
    hour_nxt = hour_r;
    day_nxt = day_r;
    mon_nxt = mon_r;
    year_nxt = year_r;
    wday_nxt = wday_r;
    min_carry = 1'b0;
    t = 9'h000;
    if (sec_tick)
    begin
      t = bcd_inc(sec_r, 8'h59, 8'h00);
      sec_nxt = t[7:0];
      if (t[8])
      begin
        t = bcd_inc(min_r, 8'h59, 8'h00);
        min_nxt = t[7:0];
        min_carry = 1'b1;
        if (t[8])
        begin
          t = bcd_inc(hour_r, 8'h23, 8'h00);
          hour_nxt = t[7:0];
          if (t[8])
          begin
            wday_nxt = (wday_r == 3'h6) ? 3'h0 : wday_r + 3'h1;
            t = bcd_inc(day_r, last_day(mon_r, year_r), 8'h01);
            day_nxt = t[7:0];
            if (t[8])
            begin
              t = bcd_inc(mon_r, 8'h12, 8'h01);
              mon_nxt = t[7:0];
              if (t[8])
              begin
                t = bcd_inc(year_r, 8'h99, 8'h00);
                year_nxt = t[7:0];
              end
            end
          end
        end
      end
    end
    // Field widths follow the BCD digit layout
    if (wr_valh)
      case (ptr_r)
        2'h0:    min_nxt = {1'b0, pwdata[6:0]};
        2'h1:    wday_nxt = pwdata[2:0];
        2'h2:    mon_nxt = {3'b000, pwdata[4:0]};
        default: min_nxt = min_nxt;
      endcase
    if (wr_vall)
      case (ptr_r)
        2'h0:    sec_nxt = {1'b0, pwdata[6:0]};
        2'h1:    hour_nxt = {2'b00, pwdata[5:0]};
        2'h2:    day_nxt = {2'b00, pwdata[5:0]};
        default: year_nxt = pwdata[7:0];
      endcase
  end

  // Time and calendar fields
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_r  <= `BCC_RST_SEC;
      min_r  <= `BCC_RST_SEC;
      hour_r <= `BCC_RST_SEC;
      wday_r <= 3'h0;
      day_r  <= `BCC_RST_DAY;
      mon_r  <= `BCC_RST_MONTH;
      year_r <= `BCC_RST_SEC;
    end
    else
    begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hour_r <= hour_nxt;
      wday_r <= wday_nxt;
      day_r  <= day_nxt;
      mon_r  <= mon_nxt;
      year_r <= year_nxt;
    end
  end

  // Alarm compare on the updated time, widening with the mask
  wire m_s1 = asec_r[3:0] == sec_r[3:0];
  wire m_s  = asec_r == sec_r;
  wire m_m1 = m_s & (amin_r[3:0] == min_r[3:0]);
  wire m_m  = m_s & (amin_r == min_r);
  wire m_h  = m_m & (ahr_r == hour_r);
  reg  al_match;
  always @*
  begin
    case (mask_r)
      4'h0:    al_match = chk_r;
      4'h1:    al_match = chk_sec_r;
      4'h2:    al_match = chk_sec_r & m_s1;
      4'h3:    al_match = chk_sec_r & m_s;
      4'h4:    al_match = chk_sec_r & m_m1;
      4'h5:    al_match = chk_sec_r & m_m;
      4'h6:    al_match = chk_sec_r & m_h;
      4'h7:    al_match = chk_sec_r & m_h & (awd_r == wday_r);
      4'h8:    al_match = chk_sec_r & m_h & (aday_r == day_r);
      4'h9:    al_match = chk_sec_r & m_h & (aday_r == day_r) &
                          (amon_r == mon_r);
      default: al_match = 1'b0;
    endcase
  end
  wire al_event = al_en_r & al_match;

  // Control registers, pointers, alarm state; power-on reset only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_r <= 1'b0;
      wren_r <= 1'b0;
      oe_r <= 1'b0;
      ptr_r <= 2'h0;
      cal_r <= `BCC_RST_CTRL;
      sel_r <= 2'h0;
      al_en_r <= 1'b0;
      chime_r <= 1'b0;
      mask_r <= 4'h0;
      aptr_r <= 2'h0;
      rpt_r <= `BCC_RST_CTRL;
      {asec_r, amin_r, ahr_r, aday_r, amon_r} <= 40'h0;
      awd_r <= 3'h0;
      chk_r <= 1'b0;
      chk_sec_r <= 1'b0;
      al_pulse_r <= 1'b0;
    end
    else
    begin
      chk_r <= sec_tick | half_tick;
      chk_sec_r <= sec_tick;
      if (al_event)
        al_pulse_r <= 1'b1;
      else if (half_tick | sec_tick)
        al_pulse_r <= 1'b0;
      if (wr_done & (a8 == `BCC_OFF_CFG))
      begin
        if (wren_r)
          en_r <= pwdata[`BCC_CFG_EN];
        wren_r <= pwdata[`BCC_CFG_WREN];
        oe_r <= pwdata[`BCC_CFG_OE];
        ptr_r <= pwdata[`BCC_CFG_PTR_HI:`BCC_CFG_PTR_LO];
      end
      else if (hit_valh && ptr_r != 2'h0)
        ptr_r <= ptr_r - 2'h1;
      if (wr_done & (a8 == `BCC_OFF_CAL))
        cal_r <= pwdata[7:0];
      if (wr_done & (a8 == `BCC_OFF_PAD))
        sel_r <= pwdata[`BCC_PAD_SEL_HI:`BCC_PAD_SEL_LO];
      if (wr_done & (a8 == `BCC_OFF_ALCFG))
      begin
        al_en_r <= pwdata[`BCC_ACF_EN];
        chime_r <= pwdata[`BCC_ACF_CHIME];
        mask_r <= pwdata[`BCC_ACF_MASK_HI:`BCC_ACF_MASK_LO];
        aptr_r <= pwdata[1:0];
      end
      else if (hit_alvh && aptr_r != 2'h0)
        aptr_r <= aptr_r - 2'h1;
      // Alarm event beats a same-cycle repeat write
      if (al_event)
      begin
        if (rpt_r != 8'h00)
          rpt_r <= rpt_r - 8'h01;
        else if (chime_r)
          rpt_r <= 8'hff;
        else
          al_en_r <= 1'b0;
      end
      else if (wr_done & (a8 == `BCC_OFF_ALRPT))
        rpt_r <= pwdata[7:0];
      if (wr_done & (a8 == `BCC_OFF_ALVALH))
        case (aptr_r)
          2'h0:    amin_r <= {1'b0, pwdata[6:0]};
          2'h1:    awd_r <= pwdata[2:0];
          2'h2:    amon_r <= {3'b000, pwdata[4:0]};
          default: amin_r <= amin_r;
        endcase
      if (wr_done & (a8 == `BCC_OFF_ALVALL))
        case (aptr_r)
          2'h0:    asec_r <= {1'b0, pwdata[6:0]};
          2'h1:    ahr_r <= {2'b00, pwdata[5:0]};
          2'h2:    aday_r <= {2'b00, pwdata[5:0]};
          default: asec_r <= asec_r;
        endcase
    end
  end

  // Read data mux, evaluated in the setup phase
  always @*
  begin
    mapped = 1'b1;
    rd_nxt = 8'h00;
    case (a8)
      `BCC_OFF_CFG:   rd_nxt = {en_r, 1'b0, wren_r, sync_now, half_r,
                                oe_r, ptr_r};
      `BCC_OFF_CAL:   rd_nxt = cal_r;
      `BCC_OFF_PAD:   rd_nxt = {5'h00, sel_r, 1'b0};
      `BCC_OFF_ALCFG: rd_nxt = {al_en_r, chime_r, mask_r, aptr_r};
      `BCC_OFF_ALRPT: rd_nxt = rpt_r;
      `BCC_OFF_VALH:
        case (ptr_r)
          2'h0:    rd_nxt = min_r;
          2'h1:    rd_nxt = {5'h00, wday_r};
          2'h2:    rd_nxt = mon_r;
          default: rd_nxt = 8'h00;
        endcase
      `BCC_OFF_VALL:
        case (ptr_r)
          2'h0:    rd_nxt = sec_r;
          2'h1:    rd_nxt = hour_r;
          2'h2:    rd_nxt = day_r;
          default: rd_nxt = year_r;
        endcase
      `BCC_OFF_ALVALH:
        case (aptr_r)
          2'h0:    rd_nxt = amin_r;
          2'h1:    rd_nxt = {5'h00, awd_r};
          2'h2:    rd_nxt = amon_r;
          default: rd_nxt = 8'h00;
        endcase
      `BCC_OFF_ALVALL:
        case (aptr_r)
          2'h0:    rd_nxt = asec_r;
          2'h1:    rd_nxt = ahr_r;
          2'h2:    rd_nxt = aday_r;
          default: rd_nxt = 8'h00;
        endcase
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase, registered data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= {24'h000000, rd_nxt};
      else if (acc_end)
        prdata <= 32'h0000_0000;
    end
  end

  // Output pin source and gate
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_out_r <= 1'b0;
    else if (!oe_r)
      clock_out_r <= 1'b0;
    else
      case (sel_r)
        `BCC_SEL_ALARM:  clock_out_r <= al_pulse_r;
        `BCC_SEL_SECOND: clock_out_r <= ~half_r;
        `BCC_SEL_SOURCE: clock_out_r <= src_lvl;
        default:         clock_out_r <= 1'b0;
      endcase
  end

endmodule

// ==== bcc_defs.vh ====
/*
  Constants of the BCD clock and calendar: APB register offsets, field
  positions, reset values and source-clock tick counts.
  Assumes inclusion by the design, its checker and its bench.
*/
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH

// Register byte offsets
`define BCC_OFF_CFG        8'h00
`define BCC_OFF_CAL        8'h04
`define BCC_OFF_PAD        8'h08
`define BCC_OFF_ALCFG      8'h0c
`define BCC_OFF_ALRPT      8'h10
`define BCC_OFF_VALH       8'h14
`define BCC_OFF_VALL       8'h18
`define BCC_OFF_ALVALH     8'h1c
`define BCC_OFF_ALVALL     8'h20

// clock_config fields
`define BCC_CFG_EN         7
`define BCC_CFG_WREN       5
`define BCC_CFG_SYNC       4
`define BCC_CFG_HALF       3
`define BCC_CFG_OE         2
`define BCC_CFG_PTR_HI     1
`define BCC_CFG_PTR_LO     0

// pad_output_config field
`define BCC_PAD_SEL_HI     2
`define BCC_PAD_SEL_LO     1

// alarm config fields
`define BCC_ACF_EN         7
`define BCC_ACF_CHIME      6
`define BCC_ACF_MASK_HI    5
`define BCC_ACF_MASK_LO    2

// Output source select codes
`define BCC_SEL_ALARM      2'h0
`define BCC_SEL_SECOND     2'h1
`define BCC_SEL_SOURCE     2'h2

// Reset values: 00:00:00, weekday 0, 01-01-2000
`define BCC_RST_CTRL       8'h00
`define BCC_RST_SEC        8'h00
`define BCC_RST_DAY        8'h01
`define BCC_RST_MONTH      8'h01

// Source clock ticks: 32768 per second, half second at 16384
`define BCC_SEC_LAST       16'h7fff
`define BCC_HALF_POINT     16'h4000
`define BCC_SYNC_TICKS     16'h0020

`endif

// ==== bcc_clock_calendar_assertions.sv ====
/*
  Port checker for the BCD clock and calendar: APB timing, readback of
  software fields and the output pin gate.
  Assumes it sees only the top ports; writable fields are shadowed here.
*/
`timescale 1ns/100ps
`include "bcc_defs.vh"
module bcc_checker
#(
  parameter ADDR_W = 8
)
(
  // APB
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  // Sources and pin
  input wire              internal_oscillator,
  input wire              secondary_oscillator,
  input wire              source_osc_fuse,
  input wire              clock_out_r
);
  reg       en_r;
  reg       wren_r;
  reg       oe_r;
  reg [1:0] ptr_r;
  reg [1:0] sel_r;
  reg [7:0] cal_r;
  wire      acc = psel && penable && pready;
  wire      rdc = acc && !pwrite && paddr == `BCC_OFF_CFG;
  wire      map = paddr[1:0] == 2'h0 && paddr <= `BCC_OFF_ALVALL;

  // Shadow of the software visible fields
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_r <= 1'b0;
      wren_r <= 1'b0;
      oe_r <= 1'b0;
      ptr_r <= 2'h0;
      sel_r <= 2'h0;
      cal_r <= 8'h00;
    end
    else
    begin
      if (acc && pwrite && paddr == `BCC_OFF_CFG)
      begin
        wren_r <= pwdata[5];
        oe_r <= pwdata[2];
        ptr_r <= pwdata[1:0];
        if (wren_r)
          en_r <= pwdata[7];
      end
      else if (acc && paddr == `BCC_OFF_VALH && ptr_r != 2'h0)
        ptr_r <= ptr_r - 2'h1;
      if (acc && pwrite && paddr == `BCC_OFF_CAL)
        cal_r <= pwdata[7:0];
      if (acc && pwrite && paddr == `BCC_OFF_PAD)
        sel_r <= pwdata[2:1];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pready |-> pslverr == !map; endproperty
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  property p_en; rdc |-> prdata[7] == en_r && prdata[5] == wren_r; endproperty
  property p_ptr; rdc |-> prdata[1:0] == ptr_r; endproperty
  property p_oe; rdc |-> prdata[2] == oe_r && !prdata[6]; endproperty
  property p_sync; rdc && !en_r |-> !prdata[4]; endproperty
  property p_pad;
    acc && !pwrite && paddr == `BCC_OFF_PAD |-> prdata[7:0] == {sel_r, 1'b0};
  endproperty
  property p_cal;
    acc && !pwrite && paddr == `BCC_OFF_CAL |-> prdata[7:0] == cal_r;
  endproperty
  property p_off; !oe_r [*3] |-> !clock_out_r; endproperty

  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_idle: assert property (p_idle) else $error("read data outside access");
  a_hi: assert property (p_hi) else $error("upper read bits not zero");
  a_en: assert property (p_en) else $error("enable readback");
  a_ptr: assert property (p_ptr) else $error("pointer readback");
  a_oe: assert property (p_oe) else $error("output enable readback");
  a_sync: assert property (p_sync) else $error("sync set while off");
  a_pad: assert property (p_pad) else $error("pad readback");
  a_cal: assert property (p_cal) else $error("calibration readback");
  a_off: assert property (p_off) else $error("pin driven while off");

  c_wr: cover property (acc && pwrite && paddr == `BCC_OFF_CFG && wren_r);
  c_err: cover property (pready && pslverr);
  c_valh: cover property (acc && paddr == `BCC_OFF_VALH && ptr_r != 2'h0);
endmodule

bind bcc_clock_calendar bcc_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ==== tb.sv ====
/*
  Testbench for the BCD clock and calendar over APB.
  Assumes a source level that toggles every pclk, so a second is 65536 cycles.
*/
`timescale 1ns/100ps
`include "bcc_defs.vh"
module tb;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, clock_out_r;
  reg         internal_oscillator, secondary_oscillator, source_osc_fuse;
  reg         osc_run, er;
  reg  [31:0] rd;
  integer     n_mismatch, checks, cycles;

  bcc_clock_calendar #(.ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_oscillator(internal_oscillator),
    .secondary_oscillator(secondary_oscillator),
    .source_osc_fuse(source_osc_fuse), .clock_out_r(clock_out_r));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Source level and hang guard
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (osc_run)
      internal_oscillator <= ~internal_oscillator;
    if (cycles == 95000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end

  task report_and_stop;
  begin
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task xfer(input [7:0] a, input w, input [7:0] d);
    integer k;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    k = 0;
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge pclk);
      k = k + 1;
    end
    // A missing answer is a mismatch of its own
    if (k == 16)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rchk(input string nm, input [7:0] a, input [7:0] e);
  begin
    xfer(a, 1'b0, 8'h00);
    chk(nm, {24'h0, e}, rd);
  end
  endtask

  // Pin activity: 2 when toggling, else its steady level
  task tog(input string nm, input [1:0] e);
    integer n;
    reg p;
  begin
    n = 0;
    repeat (4) @(posedge pclk);
    p = clock_out_r;
    repeat (16)
    begin
      @(posedge pclk);
      if (clock_out_r !== p)
        n = n + 1;
      p = clock_out_r;
    end
    chk(nm, {30'h0, e}, (n > 0) ? 32'h2 : {31'h0, p});
  end
  endtask

  task t_reset;
  begin
    rchk("cfg", `BCC_OFF_CFG, 8'h00);
    rchk("cal", `BCC_OFF_CAL, 8'h00);
    rchk("pad", `BCC_OFF_PAD, 8'h00);
    rchk("alcfg", `BCC_OFF_ALCFG, 8'h00);
    rchk("alrpt", `BCC_OFF_ALRPT, 8'h00);
    xfer(8'h24, 1'b0, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, er});
    wr(8'hfc, 8'hff);
    chk("unmapped wr err", 32'h1, {31'h0, er});
  end
  endtask

  task t_lock;
  begin
    wr(`BCC_OFF_CFG, 8'h80);
    rchk("locked en", `BCC_OFF_CFG, 8'h00);
    wr(`BCC_OFF_VALL, 8'h30);
    rchk("locked sec", `BCC_OFF_VALL, 8'h00);
    wr(`BCC_OFF_CFG, 8'h20);
    wr(`BCC_OFF_CFG, 8'ha0);
    rchk("en set", `BCC_OFF_CFG, 8'ha0);
    wr(`BCC_OFF_CFG, 8'h20);
  end
  endtask

  task t_ptr(input [7:0] c, input [7:0] h, input [7:0] b);
    integer i;
  begin
    wr(c, b | 8'h03);
    for (i = 0; i < 4; i = i + 1)
    begin
      xfer(h, 1'b0, 8'h00);
      xfer(c, 1'b0, 8'h00);
      chk("ptr", (i < 3) ? 2 - i : 0, {30'h0, rd[1:0]});
    end
  end
  endtask

  task t_cal;
  begin
    wr(`BCC_OFF_CAL, 8'h7f);
    rchk("cal max", `BCC_OFF_CAL, 8'h7f);
    wr(`BCC_OFF_CAL, 8'h80);
    rchk("cal min", `BCC_OFF_CAL, 8'h80);
    wr(`BCC_OFF_CAL, 8'h00);
  end
  endtask

  task t_out;
  begin
    osc_run = 1'b1;
    wr(`BCC_OFF_CFG, 8'h24);
    wr(`BCC_OFF_PAD, 8'h04);
    rchk("pad", `BCC_OFF_PAD, 8'h04);
    tog("pin source", 2'h2);
    source_osc_fuse <= 1'b1;
    tog("pin fuse", 2'h0);
    source_osc_fuse <= 1'b0;
    wr(`BCC_OFF_PAD, 8'h06);
    tog("pin reserved", 2'h0);
    wr(`BCC_OFF_PAD, 8'h00);
    tog("pin alarm", 2'h0);
    wr(`BCC_OFF_PAD, 8'h02);
    tog("pin second", 2'h1);
    wr(`BCC_OFF_PAD, 8'h04);
    wr(`BCC_OFF_CFG, 8'h20);
    tog("pin off", 2'h0);
    osc_run = 1'b0;
  end
  endtask

  // Leap day rollover at end of 2000-02-28 with half second alarms
  task t_time;
  begin
    wr(`BCC_OFF_ALCFG, 8'h80);
    wr(`BCC_OFF_ALRPT, 8'h02);
    wr(`BCC_OFF_CFG, 8'ha3);
    osc_run = 1'b1;
    wr(`BCC_OFF_VALL, 8'h00);
    wr(`BCC_OFF_VALH, 8'h00);
    wr(`BCC_OFF_VALL, 8'h28);
    wr(`BCC_OFF_VALH, 8'h02);
    wr(`BCC_OFF_VALL, 8'h23);
    wr(`BCC_OFF_VALH, 8'h06);
    wr(`BCC_OFF_VALL, 8'h59);
    wr(`BCC_OFF_VALH, 8'h59);
    rchk("half clear", `BCC_OFF_CFG, 8'ha0);
    repeat (40000) @(posedge pclk);
    rchk("half set", `BCC_OFF_CFG, 8'ha8);
    rchk("repeat 1", `BCC_OFF_ALRPT, 8'h01);
    repeat (28000) @(posedge pclk);
    wr(`BCC_OFF_CFG, 8'ha3);
    rchk("year", `BCC_OFF_VALL, 8'h00);
    rchk("year twice", `BCC_OFF_VALL, 8'h00);
    rchk("reserved", `BCC_OFF_VALH, 8'h00);
    rchk("day", `BCC_OFF_VALL, 8'h29);
    rchk("month", `BCC_OFF_VALH, 8'h02);
    rchk("hour", `BCC_OFF_VALL, 8'h00);
    rchk("weekday", `BCC_OFF_VALH, 8'h00);
    rchk("second", `BCC_OFF_VALL, 8'h00);
    rchk("minute", `BCC_OFF_VALH, 8'h00);
    rchk("repeat 0", `BCC_OFF_ALRPT, 8'h00);
    rchk("alarm on", `BCC_OFF_ALCFG, 8'h80);
  end
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    internal_oscillator = 1'b0;
    secondary_oscillator = 1'b0;
    source_osc_fuse = 1'b0;
    osc_run = 1'b0;
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_lock;
    t_ptr(`BCC_OFF_CFG, `BCC_OFF_VALH, 8'h20);
    t_ptr(`BCC_OFF_ALCFG, `BCC_OFF_ALVALH, 8'h00);
    t_cal;
    t_out;
    t_time;
    report_and_stop;
  end
endmodule
